// File: hw/tdcr_readout.sv
// Purpose: two-channel TDC result, status and config readback bank
// Assumes: pins synchronous to REF_CLK, one fine step per clock
// Notes:   results are written only by the arithmetic unit
`timescale 1ns/100ps
// How it works
// - four read-only 32-bit results at indices 0..3, format 16.16
// - status bits 2:0 point at next free result, advance on store
// - status 5:3 and 8:6 count hits on stop channel 1 and 2
// - status bit 9 flags overflow of the time-measuring unit
// - status bit 10 flags 14-bit precounter overflow in range two
// - temperature run sets bit 11 for open, bit 12 for short sensor
// - negative results only in range one, range two is unsigned
// - raw output only in range one, range two always calibrated
// - calibrated range one at or beyond two reference periods stores all ones
// - calibrated results count internal reference periods, divider 1, 2 or 4
// - calibrated result fills one register, two's complement, MSB first
// - raw result is signed 16-bit count in upper half, low half zero
// - temperature result uses the range two calibrated format
// - each stop channel takes up to four hits per measurement
// - edge selection per channel is honoured when capturing hits
// - enable inputs gate start and stop, hits only inside window
// - in range one any recorded event can be differenced against any other, range two always against start
// - start begins, stop ends interval, 20-bit raw timestamp range
// - calibration measures one and two reference periods
// - range one measurement bounded by span of 26224 fine steps, range two by the precounter
// - with error value enabled a timeout stores all ones
module tdcr_readout (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    // wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_WR,
    output logic [31:0]      WB_DAT_RD,
    output logic             WB_ACK,
    // measurement pins
    input  wire logic        START_IN,
    input  wire logic        STOP1_IN,
    input  wire logic        STOP2_IN,
    input  wire logic        EN_START,
    input  wire logic        EN_STOP1,
    input  wire logic        EN_STOP2,
    input  wire logic        SENSE_DONE,
    // state
    output logic             BUSY
);
    import tdcr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic [23:0]  ctrl_reg;
    logic         ack_reg;
    logic [31:0]  rd_data_reg;
    logic [31:0]  res_reg [4];
    logic [2:0]   ptr_reg;
    logic         to_tdc_reg;
    logic         to_pre_reg;
    logic         open_reg;
    logic         short_reg;
    tdcr_state_t  state_reg;
    logic [19:0]  ts_reg;
    logic [13:0]  pre_reg;
    logic [19:0]  start_ts_reg;
    logic         start_seen_reg;
    logic [19:0]  cal1_reg;
    logic [19:0]  cal2_reg;
    logic [1:0]   cal_phase_reg;
    logic [7:0]   div_cnt_reg;
    logic [7:0]   div_top;
    logic         ref_tick;
    logic [2:0]   pin_prev_reg;
    logic [2:0]   pin_now;
    logic [2:0]   pin_en;
    logic [2:0]   edge_hit;
    logic [19:0]  stop_ts [8];
    logic [2:0]   hit_cnt [2];
    logic [2:0]   hit_max [2];
    logic         alu_go_reg;
    logic [19:0]  alu_a_reg;
    logic [19:0]  alu_b_reg;
    logic         alu_uns_reg;
    logic         alu_err_reg;
    logic         alu_done;
    logic [31:0]  alu_result;
    logic [5:0]   bus_idx;
    logic         bus_wr;
    logic         cmd_init;
    logic         cmd_cal;
    logic         cmd_calc;
    logic         cmd_temp;
    logic         meas_done;
    logic         tdc_over;
    logic         pre_over;
    logic [15:0]  status;

    ////////////////////////////////////////////////////////////////////
    // wishbone slave, one wait state, unmapped reads return zero

    assign bus_idx  = WB_ADR[7:2];
    assign bus_wr   = WB_CYC && WB_STB && WB_WE && !ack_reg;
    // commands only while idle, so a running job is never half cleared
    assign cmd_init = bus_wr && !BUSY && bus_idx == IDX_CMD && WB_SEL[0] && WB_DAT_WR[CMD_INIT];
    assign cmd_cal  = bus_wr && !BUSY && bus_idx == IDX_CMD && WB_SEL[0] && WB_DAT_WR[CMD_CAL];
    assign cmd_calc = bus_wr && !BUSY && bus_idx == IDX_CMD && WB_SEL[0] && WB_DAT_WR[CMD_CALC];
    assign cmd_temp = bus_wr && !BUSY && bus_idx == IDX_CMD && WB_SEL[0] && WB_DAT_WR[CMD_TEMP];
    assign WB_ACK   = ack_reg;
    assign WB_DAT_RD = rd_data_reg;
    assign BUSY     = state_reg != ST_IDLE;

    assign status = {3'h0, short_reg, open_reg, to_pre_reg, to_tdc_reg,
                     hit_cnt[1], hit_cnt[0], ptr_reg};

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= WB_CYC && WB_STB && !ack_reg;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rd_data_reg <= 32'h0000_0000;
        end else if (WB_CYC && WB_STB && !WB_WE && !ack_reg) begin
            case (bus_idx)
                6'h00, 6'h01, 6'h02, 6'h03: rd_data_reg <= res_reg[bus_idx[1:0]];
                IDX_STAT:  rd_data_reg <= {16'h0000, status};
                IDX_CFGRB: rd_data_reg <= {24'h00_0000, ctrl_reg[23:16]};
                IDX_CTRL:  rd_data_reg <= {8'h00, ctrl_reg};
                IDX_CMD:   rd_data_reg <= {31'h0, BUSY};
                default:   rd_data_reg <= 32'h0000_0000;
            endcase
        end
    end

    // control bytes, the top byte is not implemented
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_reg <= CTRL_RST;
        end else if (bus_wr && bus_idx == IDX_CTRL) begin
            for (int b = 0; b < 3; b++) begin
                if (WB_SEL[b]) begin
                    ctrl_reg[8*b +: 8] <= WB_DAT_WR[8*b +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // internal reference tick, external reference divided by 1, 2 or 4

    always_comb begin
        case (ctrl_reg[CTL_DIV +: 2])
            2'd0:    div_top = 8'(REF_BASE_CYC - 1);
            2'd1:    div_top = 8'(2 * REF_BASE_CYC - 1);
            default: div_top = 8'(4 * REF_BASE_CYC - 1);
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || div_cnt_reg >= div_top) begin
            div_cnt_reg <= 8'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'd1;
        end
    end
    assign ref_tick = div_cnt_reg == div_top;

    ////////////////////////////////////////////////////////////////////
    // edge detection per input: start, stop 1, stop 2

    assign pin_now = {STOP2_IN, STOP1_IN, START_IN};
    assign pin_en  = {EN_STOP2, EN_STOP1, EN_START};

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pin_prev_reg <= 3'h0;
        end else begin
            pin_prev_reg <= pin_now;
        end
    end

    generate
        for (genvar c = 0; c < 3; c++) begin : g_edge
            logic both;
            assign both = (c == 0) ? 1'b0 : ctrl_reg[CTL_BOTH + c - 1];
            // hits outside the enable window are dropped
            assign edge_hit[c] = pin_en[c] &&
                (both ? (pin_now[c] ^ pin_prev_reg[c]) :
                 ctrl_reg[CTL_FALL + c] ? (pin_prev_reg[c] && !pin_now[c]) :
                 (!pin_prev_reg[c] && pin_now[c]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // stop channel hit capture

    assign hit_max[0] = ctrl_reg[CTL_HIT1 +: 3];
    assign hit_max[1] = ctrl_reg[CTL_HIT2 +: 3];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_stop
            logic [19:0] ts_q [4];
            logic [2:0]  cnt_q;
            logic        take;
            // a stop before the start is not an interval end
            assign take = state_reg == ST_MEAS && start_seen_reg && edge_hit[c + 1] &&
                          cnt_q < hit_max[c] && cnt_q < 3'd4;
            always_ff @(posedge REF_CLK) begin
                if (SYS_RST || cmd_init) begin
                    cnt_q <= 3'd0;
                end else if (take) begin
                    cnt_q <= cnt_q + 3'd1;
                end
            end
            always_ff @(posedge REF_CLK) begin
                if (take) begin
                    ts_q[cnt_q[1:0]] <= ts_reg;
                end
            end
            assign hit_cnt[c] = cnt_q;
            for (genvar k = 0; k < 4; k++) begin : g_ts
                assign stop_ts[c*4 + k] = ts_q[k];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // measurement sequencing

    assign meas_done = start_seen_reg && hit_cnt[0] >= hit_max[0] &&
                       hit_cnt[1] >= hit_max[1];
    assign tdc_over  = !ctrl_reg[CTL_MR2] && ts_reg >= TDC_SPAN - 20'd1;
    assign pre_over  = ctrl_reg[CTL_MR2] && ref_tick && pre_reg == 14'h3FFF;

    // operand selection, any event against any other in range one, range two forces start as operand B
    function automatic logic [19:0] pick(input logic [3:0] code);
        case (code)
            OP_START: pick = start_ts_reg;
            OP_CAL1:  pick = cal1_reg;
            OP_CAL2:  pick = cal2_reg;
            4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hC:
                pick = stop_ts[{code[3], 2'(code[1:0] - 2'd1)}];
            default:  pick = 20'h0_0000;
        endcase
    endfunction

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_reg     <= ST_IDLE;
            ts_reg        <= 20'h0_0000;
            pre_reg       <= 14'h0000;
            cal_phase_reg <= 2'd0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    ts_reg  <= 20'h0_0000;
                    pre_reg <= 14'h0000;
                    if (cmd_init) begin
                        state_reg <= ST_MEAS;
                    end else if (cmd_cal) begin
                        cal_phase_reg <= 2'd0;
                        state_reg     <= ST_CALIB;
                    end else if (cmd_calc && ctrl_reg[CTL_OPA +: 4] != OP_NONE) begin
                        state_reg <= ST_CALC;
                    end else if (cmd_temp) begin
                        state_reg <= ST_TEMP;
                    end
                end
                ST_MEAS: begin
                    ts_reg <= ts_reg + 20'd1;
                    if (ref_tick) begin
                        pre_reg <= pre_reg + 14'd1;
                    end
                    if (meas_done || tdc_over || pre_over) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CALIB: begin
                    ts_reg <= ts_reg + 20'd1;
                    if (ref_tick) begin
                        cal_phase_reg <= cal_phase_reg + 2'd1;
                        if (cal_phase_reg == 2'd0) begin
                            ts_reg <= 20'h0_0001;
                        end
                        if (cal_phase_reg == 2'd2) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_CALC: begin
                    if (alu_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_TEMP: begin
                    ts_reg <= ts_reg + 20'd1;
                    if (SENSE_DONE) begin
                        state_reg <= ST_CALC;
                    end else if (ts_reg == TEMP_LIMIT) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // start stamp
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || cmd_init) begin
            start_seen_reg <= 1'b0;
            start_ts_reg   <= 20'h0_0000;
        end else if (state_reg == ST_MEAS && edge_hit[0] && !start_seen_reg) begin
            start_seen_reg <= 1'b1;
            start_ts_reg   <= ts_reg;
        end
    end

    // calibration stamps, one and two reference periods
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            cal1_reg <= 20'h0_0000;
            cal2_reg <= 20'h0_0000;
        end else if (state_reg == ST_CALIB && ref_tick) begin
            if (cal_phase_reg == 2'd1) begin
                cal1_reg <= ts_reg;
            end
            if (cal_phase_reg == 2'd2) begin
                cal2_reg <= ts_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags, a setting event wins over the init clear

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            to_tdc_reg <= 1'b0;
            to_pre_reg <= 1'b0;
            open_reg   <= 1'b0;
            short_reg  <= 1'b0;
        end else begin
            to_tdc_reg <= (to_tdc_reg && !cmd_init) ||
                          (state_reg == ST_MEAS && tdc_over);
            to_pre_reg <= (to_pre_reg && !cmd_init) ||
                          (state_reg == ST_MEAS && pre_over);
            open_reg   <= (open_reg && !cmd_init && !cmd_temp) ||
                          (state_reg == ST_TEMP && !SENSE_DONE &&
                           ts_reg == TEMP_LIMIT);
            short_reg  <= (short_reg && !cmd_init && !cmd_temp) ||
                          (state_reg == ST_TEMP && SENSE_DONE &&
                           ts_reg < 20'(SHORT_MIN_CYC));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // arithmetic unit launch and result store

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            alu_go_reg  <= 1'b0;
            alu_a_reg   <= 20'h0_0000;
            alu_b_reg   <= 20'h0_0000;
            alu_uns_reg <= 1'b0;
            alu_err_reg <= 1'b0;
        end else begin
            alu_go_reg <= 1'b0;
            if (state_reg == ST_IDLE && !cmd_init && !cmd_cal && cmd_calc &&
                ctrl_reg[CTL_OPA +: 4] != OP_NONE) begin
                alu_go_reg  <= 1'b1;
                alu_a_reg   <= pick(ctrl_reg[CTL_OPA +: 4]);
                alu_b_reg   <= ctrl_reg[CTL_MR2] ? start_ts_reg :
                               pick(ctrl_reg[CTL_OPB +: 4]);
                alu_uns_reg <= ctrl_reg[CTL_MR2];
                alu_err_reg <= ctrl_reg[CTL_ERRV] && (to_tdc_reg || to_pre_reg);
            end else if (state_reg == ST_TEMP && SENSE_DONE) begin
                alu_go_reg  <= 1'b1;
                alu_a_reg   <= ts_reg;
                alu_b_reg   <= 20'h0_0000;
                alu_uns_reg <= 1'b1;
                alu_err_reg <= 1'b0;
            end
        end
    end

    tdcr_alu u_alu (
        .clk           (REF_CLK),
        .rst           (SYS_RST),
        .go            (alu_go_reg),
        .op_a          (alu_a_reg),
        .op_b          (alu_b_reg),
        .tref          (cal2_reg - cal1_reg),
        .calibrate     (ctrl_reg[CTL_CAL] || alu_uns_reg),
        .unsigned_mode (alu_uns_reg),
        .force_err     (alu_err_reg),
        .done          (alu_done),
        .result        (alu_result)
    );

    // results stay readable after init, only the pointer restarts
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ptr_reg <= 3'd0;
            for (int i = 0; i < 4; i++) begin
                res_reg[i] <= 32'h0000_0000;
            end
        end else if (alu_done && ptr_reg < 3'd4) begin
            res_reg[ptr_reg[1:0]] <= alu_result;
            ptr_reg <= ptr_reg + 3'd1;
        end else if (cmd_init) begin
            ptr_reg <= 3'd0;
        end
    end
endmodule

// File: hw/tdcr_pkg.sv
// Purpose: shared constants for the TDC result and status readout
// Assumes: 125 MHz system clock, register index = byte address / 4
// Notes:   control and command layouts are local to this design
package tdcr_pkg;
    // register indices, byte address is index * 4
    localparam logic [5:0] IDX_RES0  = 6'h00;
    localparam logic [5:0] IDX_STAT  = 6'h04;
    localparam logic [5:0] IDX_CFGRB = 6'h05;
    localparam logic [5:0] IDX_CTRL  = 6'h06;
    localparam logic [5:0] IDX_CMD   = 6'h07;
    // control register fields
    localparam int CTL_OPA  = 0;
    localparam int CTL_OPB  = 4;
    localparam int CTL_HIT1 = 8;
    localparam int CTL_HIT2 = 11;
    localparam int CTL_CAL  = 14;
    localparam int CTL_MR2  = 15;
    localparam int CTL_DIV  = 16;
    localparam int CTL_ERRV = 18;
    localparam int CTL_FALL = 19;
    localparam int CTL_BOTH = 22;
    localparam logic [23:0] CTRL_RST = 24'h00_4901;
    // command bits, write one to trigger
    localparam int CMD_INIT = 0;
    localparam int CMD_CAL  = 1;
    localparam int CMD_CALC = 2;
    localparam int CMD_TEMP = 3;
    // status fields
    localparam int ST_PTR   = 0;
    localparam int ST_HIT1  = 3;
    localparam int ST_HIT2  = 6;
    localparam int ST_TOTDC = 9;
    localparam int ST_TOPRE = 10;
    localparam int ST_OPEN  = 11;
    localparam int ST_SHORT = 12;
    // operand codes
    localparam logic [3:0] OP_START = 4'h0;
    localparam logic [3:0] OP_NONE  = 4'h5;
    localparam logic [3:0] OP_CAL1  = 4'h6;
    localparam logic [3:0] OP_CAL2  = 4'h7;
    // limits and timing
    localparam logic [19:0] TDC_SPAN   = 20'h0_6670;
    localparam logic [19:0] TEMP_LIMIT = 20'hF_FFFF;
    localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
    localparam int CLK_PERIOD_NS = 8;
    localparam int REF_PERIOD_NS = 64;
    localparam int REF_BASE_CYC  = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_MIN_NS  = 2000;
    localparam int SHORT_MIN_CYC = (SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MEAS,
        ST_CALIB,
        ST_CALC,
        ST_TEMP
    } tdcr_state_t;
endpackage

// File: hw/tdcr_alu.sv
// Purpose: result arithmetic unit, operand difference and calibration
// Assumes: go is a one-cycle pulse while idle, operands held by caller
// Notes:   restoring divider, 37 shift steps, done 38 cycles after go per calibrated result
`timescale 1ns/100ps
module tdcr_alu (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request
    input  wire logic        go,
    input  wire logic [19:0] op_a,
    input  wire logic [19:0] op_b,
    input  wire logic [19:0] tref,
    input  wire logic        calibrate,
    input  wire logic        unsigned_mode,
    input  wire logic        force_err,
    // answer
    output logic             done,
    output logic [31:0]      result
);
    import tdcr_pkg::*;

    logic [20:0] diff;
    logic [20:0] mag;
    logic        neg_reg;
    logic [36:0] num_reg;
    logic [20:0] rem_reg;
    logic [20:0] rem_sh;
    logic [5:0]  cnt_reg;
    logic        run_reg;

    assign diff   = {1'b0, op_a} - {1'b0, op_b};
    assign mag    = (diff[20] && !unsigned_mode) ? 21'(-diff) : {1'b0, diff[19:0]};
    assign rem_sh = {rem_reg[19:0], num_reg[36]};

    always_ff @(posedge clk) begin
        if (rst) begin
            run_reg <= 1'b0;
            done    <= 1'b0;
            result  <= 32'h0000_0000;
            cnt_reg <= 6'h00;
            num_reg <= 37'h0;
            rem_reg <= 21'h0;
            neg_reg <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) begin
                if (force_err) begin
                    result <= ALL_ONES;
                    done   <= 1'b1;
                end else if (!calibrate && !unsigned_mode) begin
                    result <= {diff[15:0], 16'h0000};
                    done   <= 1'b1;
                end else if (tref == 20'h0_0000 ||
                             (!unsigned_mode && mag >= {tref, 1'b0})) begin
                    result <= ALL_ONES;
                    done   <= 1'b1;
                end else begin
                    // scale to 16.16 in reference periods
                    num_reg <= {mag[20:0], 16'h0000};
                    rem_reg <= 21'h0;
                    neg_reg <= diff[20] && !unsigned_mode;
                    cnt_reg <= 6'd37;
                    run_reg <= 1'b1;
                end
            end else if (run_reg && cnt_reg != 6'd0) begin
                if (rem_sh >= {1'b0, tref}) begin
                    rem_reg <= rem_sh - {1'b0, tref};
                    num_reg <= {num_reg[35:0], 1'b1};
                end else begin
                    rem_reg <= rem_sh;
                    num_reg <= {num_reg[35:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 6'd1;
            end else if (run_reg) begin
                // quotient is complete only once the last shift has landed
                run_reg <= 1'b0;
                done    <= 1'b1;
                result  <= neg_reg ? 32'(-num_reg[31:0]) : num_reg[31:0];
            end
        end
    end
endmodule

// File: verification/tdcr_monitor.sv
// Purpose: port checks for the readout bank
// Assumes: single clock, sync reset
// Notes:   ranges only, the bench holds exact values
`timescale 1ns/100ps
module tdcr_monitor import tdcr_pkg::*; (
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        WB_CYC,
    input wire logic        WB_STB,
    input wire logic        WB_WE,
    input wire logic [7:0]  WB_ADR,
    input wire logic [31:0] WB_DAT_RD,
    input wire logic        WB_ACK
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    wire logic take = WB_CYC && WB_STB && !WB_ACK;
    wire logic rd = take && !WB_WE;
    wire logic rd_st = rd && WB_ADR[7:2] == IDX_STAT;
    ack_answer_a: assert property (take |=> WB_ACK) else $error("ack missing");
    ack_pulse_a: assert property (WB_ACK |=> !WB_ACK) else $error("ack too long");
    ack_cause_a: assert property (WB_ACK |-> $past(take)) else $error("stray ack");
    unmapped_zero_a: assert property (rd && WB_ADR[7:2] > IDX_CMD |=> WB_DAT_RD == '0)
        else $error("unmapped read not zero");
    cfg_width_a: assert property (rd && WB_ADR[7:2] == IDX_CFGRB |=> WB_DAT_RD[31:8] == '0)
        else $error("readback too wide");
    st_spare_a: assert property (rd_st |=> WB_DAT_RD[31:13] == '0) else $error("spare set");
    ptr_range_a: assert property (rd_st |=> WB_DAT_RD[2:0] <= 3'h4) else $error("pointer");
    hit_cap_a: assert property (rd_st |=> WB_DAT_RD[5:3] <= 3'h4 && WB_DAT_RD[8:6] <= 3'h4)
        else $error("hit count above four");
endmodule
bind tdcr_readout tdcr_monitor mon (.REF_CLK, .SYS_RST, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR,
    .WB_DAT_RD, .WB_ACK);

// File: verification/tdcr_hit_src.sv
// Purpose: start and stop hit source
// Assumes: fire pulses for one cycle
// Notes:   lines rest low between shots
`timescale 1ns/100ps
module tdcr_hit_src #(parameter int GAP = 20) (
    input  wire logic clk,
    input  wire logic fire,
    output logic      start = 1'b0,
    output logic      stop = 1'b0
);
    int cnt = 0;
    always @(posedge clk) begin
        start <= fire;
        cnt <= fire ? GAP : (cnt > 0 ? cnt - 1 : 0);
        stop <= (cnt == 1);
    end
endmodule

// File: verification/tdc_result_status_readout_tb_top.sv
// Purpose: readout bench
// Assumes: hit gap of 20 clocks
// Notes:   timeout run takes ~26k cycles
`timescale 1ns/100ps
module tdc_result_status_readout_tb_top;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, fire = 1'b0, en2 = 1'b1, sense = 1'b0;
    logic ack, busy, start, stop;
    logic [40:0] bus = 41'h0;
    logic [31:0] rdat, rdb;
    int n_fail = 0, comparisons = 0;
    always #4 clk = ~clk;
    tdcr_hit_src src (.clk(clk), .fire(fire), .start(start), .stop(stop));
    tdcr_readout dut (.REF_CLK(clk), .SYS_RST(rst), .WB_CYC(req), .WB_STB(req),
        .WB_WE(bus[40]), .WB_ADR(bus[39:32]), .WB_SEL(4'hF), .WB_DAT_WR(bus[31:0]),
        .WB_DAT_RD(rdb), .WB_ACK(ack), .START_IN(start), .STOP1_IN(stop), .STOP2_IN(stop),
        .EN_START(1'b1), .EN_STOP1(1'b1), .EN_STOP2(en2), .SENSE_DONE(sense), .BUSY(busy));
    task automatic results;
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= 1'b1;
        bus <= {w, a, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rdat = rdb;
        req <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        comparisons++;
        if (rdat !== e) begin
            n_fail++;
            $display("Error reg %h expected %h seen %h", a, e, rdat);
        end
    endtask
    // init only arms the timestamp counter, so the shot must follow it
    task automatic cmd(input logic [31:0] c);
        acc(1'b1, 8'h1C, c);
        comparisons++;
        if (busy !== 1'b1) begin
            n_fail++;
            $display("Error busy expected 1 seen %b", busy);
        end
        fire <= (c == 32'h0000_0001);
        @(posedge clk);
        fire <= 1'b0;
        while (busy !== 1'b0) @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(8'h40, 32'h0000_0000);
        acc(1'b1, 8'h18, 32'h0000_0901);
        cmd(32'h0000_0001);
        chk(8'h10, 32'h0000_0048);
        cmd(32'h0000_0004);
        chk(8'h00, 32'h0014_0000);
        chk(8'h10, 32'h0000_0049);
        acc(1'b1, 8'h00, 32'h1234_5678);
        chk(8'h00, 32'h0014_0000);
        cmd(32'h0000_0002);
        acc(1'b1, 8'h18, 32'h0000_4901);
        cmd(32'h0000_0004);
        chk(8'h04, 32'hFFFF_FFFF);
        acc(1'b1, 8'h18, 32'h0000_4976);
        cmd(32'h0000_0004);
        chk(8'h08, 32'hFFFF_0000);
        en2 <= 1'b0;
        acc(1'b1, 8'h18, 32'h0004_0901);
        cmd(32'h0000_0001);
        chk(8'h10, 32'h0000_0208);
        chk(8'h14, 32'h0000_0004);
        cmd(32'h0000_0004);
        chk(8'h00, 32'hFFFF_FFFF);
        en2 <= 1'b1;
        acc(1'b1, 8'h18, 32'h0048_0A02);
        cmd(32'h0000_0001);
        chk(8'h10, 32'h0000_0050);
        cmd(32'h0000_0004);
        chk(8'h00, 32'h0014_0000);
        acc(1'b1, 8'h18, 32'h0048_8A01);
        cmd(32'h0000_0004);
        chk(8'h04, 32'h0002_6000);
        sense <= 1'b1;
        cmd(32'h0000_0008);
        chk(8'h10, 32'h0000_1053);
        chk(8'h08, 32'h0000_0000);
        results();
    end
endmodule
